// ==== hdl/adcrd_pkg.sv ====
// Purpose: Shared constants and types for the converter result and display control block
// Assumes: APB with 8-bit byte addresses and 32-bit data, one word per register
// Notes:   Control word layout is the packed struct below, bit 6 first
package adcrd_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int RES_W  = 20;
  localparam int HIGH_W = 16;
  localparam int NIB_W  = 4;
  localparam int CTRL_W = 7;
  localparam int IRQ_W  = 3;
  localparam int STAT_W = 2;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_CTRL        = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS      = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_RESULT_HIGH = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_RESULT_LOW  = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_DISPLAY     = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_PEAK        = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS  = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK    = 8'h1C;

  // Interrupt bit positions
  localparam int IRQ_CONV = 0;
  localparam int IRQ_BATT = 1;
  localparam int IRQ_CAL  = 2;

  // Status bit positions
  localparam int STAT_BATT = 0;
  localparam int STAT_CAL  = 1;

  // Reset values
  localparam logic [HIGH_W-1:0] HIGH_RST = 16'h0000;
  localparam logic [NIB_W-1:0]  NIB_RST  = 4'h0;
  localparam logic [IRQ_W-1:0]  IRQ_RST  = 3'h0;
  localparam logic [DATA_W-1:0] WORD_RST = 32'h0000_0000;

  typedef struct packed {
    logic hold;
    logic peak;
    logic source_serial;
    logic analog_powerdown;
    logic digital_powerdown;
    logic enhanced_offset_trigger;
    logic auto_offset_disable;
  } adcrd_ctrl_s;

  localparam adcrd_ctrl_s CTRL_RST = 7'h00;

  typedef struct packed {
    logic              negative;
    logic [HIGH_W-1:0] magnitude;
  } adcrd_lcd_s;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } adcrd_bus_e;

endpackage

// ==== hdl/adcrd_ctrl.sv ====
// Purpose: Result assembly, calibration, power-down, peak/hold display and battery flag logic
// Assumes: conv_done is a one-cycle pulse with conv_result valid; inputs synchronous to clk
// Notes:   APB slave answers with one wait state; unmapped addresses give pslverr
// Notes on behaviour
// R1 - Low result register holds four LSBs in upper nibble, lower nibble reads zero.
// R2 - Full value is high register then low nibble, one signed 20-bit word.
// R3 - Reset clears interface, display, filter and modulator control, all registers to default.
// R4 - Offset calibration runs with every conversion while automatic-offset disable is clear.
// R5 - Enhanced calibration runs only on demand when software sets its trigger bit.
// R6 - Digital and analog power-down bits act independently; both set means full shutdown.
// R7 - Digital power-down stops filter and LCD; analog stops modulator and input buffers.
// R8 - With peak capture on, the display shows the largest value since enabling.
// R9 - With freeze on, the display keeps the reading present when freeze was set.
// R10 - Battery below threshold sets battery-low status flag and the annunciator segment.
// R11 - Negative results show magnitude less one, so minus one shows as minus zero.
// R12 - Peak first takes current result, then only larger ones; clearing peak bit clears it.
// R13 - Display loads from high result, peak register or serial write per control bits.
// R14 - Frozen display is not reloaded; loading resumes at first conversion after unfreeze.
// R15 - Result registers update on every conversion regardless of peak or freeze.
`timescale 1ns/1ps
module adcrd_ctrl
  import adcrd_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              conv_done,
  input  wire logic [RES_W-1:0]  conv_result,
  input  wire logic              cal_done,
  input  wire logic              battery_below,
  output logic                   offset_cal_each,
  output logic                   enhanced_cal_request,
  output logic                   filter_run,
  output logic                   lcd_run,
  output logic                   modulator_run,
  output logic                   buffer_run,
  output logic                   battery_segment,
  output logic                   lcd_negative,
  output logic      [HIGH_W-1:0] lcd_magnitude,
  output logic                   irq
);

  adcrd_bus_e        bus_state;
  adcrd_bus_e        next_bus_state;
  logic [DATA_W-1:0] next_prdata;
  logic              next_pslverr;
  adcrd_ctrl_s       ctrl;
  adcrd_ctrl_s       next_ctrl;
  logic [HIGH_W-1:0] result_high;
  logic [HIGH_W-1:0] next_result_high;
  logic [NIB_W-1:0]  result_low;
  logic [NIB_W-1:0]  next_result_low;
  logic [HIGH_W-1:0] peak_data;
  logic [HIGH_W-1:0] next_peak_data;
  logic              peak_valid;
  logic              next_peak_valid;
  logic [HIGH_W-1:0] display_data;
  logic [HIGH_W-1:0] next_display_data;
  logic              battery_low_flag;
  logic [IRQ_W-1:0]  irq_status;
  logic [IRQ_W-1:0]  next_irq_status;
  logic [IRQ_W-1:0]  irq_mask;
  logic [IRQ_W-1:0]  next_irq_mask;
  adcrd_lcd_s        next_lcd;
  logic              access;
  logic              wr;
  logic              conv_ok;
  logic [HIGH_W-1:0] new_high;

  // Address decode shared by write strobe and error flag
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a == ADDR_CTRL) || (a == ADDR_STATUS) || (a == ADDR_RESULT_HIGH) ||
                (a == ADDR_RESULT_LOW) || (a == ADDR_DISPLAY) || (a == ADDR_PEAK) ||
                (a == ADDR_IRQ_STATUS) || (a == ADDR_IRQ_MASK);
  endfunction

  assign access   = psel && penable && (bus_state == BUS_ACK);
  assign wr       = access && pwrite && is_mapped(paddr);
  // Filter is stopped in digital power-down, so late strobes are dropped
  assign conv_ok  = conv_done && !ctrl.digital_powerdown;
  assign new_high = conv_result[RES_W-1:NIB_W];

  // APB handshake: one wait state, read data captured with pready
  always_comb begin
    next_bus_state = BUS_IDLE;
    next_prdata    = WORD_RST;
    next_pslverr   = 1'b0;
    if (psel && penable && (bus_state == BUS_IDLE)) begin
      next_bus_state = BUS_ACK;
      next_pslverr   = !is_mapped(paddr);
      if (!pwrite) begin
        if (paddr == ADDR_CTRL) begin
          next_prdata = {{(DATA_W-CTRL_W){1'b0}}, ctrl};
        end else if (paddr == ADDR_STATUS) begin
          next_prdata = {{(DATA_W-STAT_W){1'b0}}, ctrl.enhanced_offset_trigger, battery_low_flag};
        end else if (paddr == ADDR_RESULT_HIGH) begin
          next_prdata = {{(DATA_W-HIGH_W){1'b0}}, result_high};
        end else if (paddr == ADDR_RESULT_LOW) begin
          next_prdata = {{(DATA_W-2*NIB_W){1'b0}}, result_low, NIB_RST}; // R1
        end else if (paddr == ADDR_DISPLAY) begin
          next_prdata = {{(DATA_W-HIGH_W){1'b0}}, display_data};
        end else if (paddr == ADDR_PEAK) begin
          next_prdata = {{(DATA_W-HIGH_W){1'b0}}, peak_data};
        end else if (paddr == ADDR_IRQ_STATUS) begin
          next_prdata = {{(DATA_W-IRQ_W){1'b0}}, irq_status};
        end else if (paddr == ADDR_IRQ_MASK) begin
          next_prdata = {{(DATA_W-IRQ_W){1'b0}}, irq_mask};
        end
      end
    end
  end

  // Bus registers; all state cleared by the power-on reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_state <= BUS_IDLE; // R3
      prdata    <= WORD_RST;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
    end else begin
      bus_state <= next_bus_state;
      prdata    <= next_prdata;
      pready    <= (next_bus_state == BUS_ACK);
      pslverr   <= next_pslverr;
    end
  end

  // Control, result, peak and display next values
  always_comb begin
    next_ctrl         = ctrl;
    next_result_high  = result_high;
    next_result_low   = result_low;
    next_peak_data    = peak_data;
    next_peak_valid   = peak_valid;
    next_display_data = display_data;
    next_irq_mask     = irq_mask;
    if (cal_done) begin
      next_ctrl.enhanced_offset_trigger = 1'b0;
    end
    if (wr && (paddr == ADDR_CTRL)) begin
      next_ctrl = adcrd_ctrl_s'(pwdata[CTRL_W-1:0]);
      // Trigger writes of zero do not abort; a new set wins over cal_done
      next_ctrl.enhanced_offset_trigger = next_ctrl.enhanced_offset_trigger ||
                                          (ctrl.enhanced_offset_trigger && !cal_done); // R5
    end
    if (wr && (paddr == ADDR_IRQ_MASK)) begin
      next_irq_mask = pwdata[IRQ_W-1:0];
    end
    if (conv_ok) begin
      next_result_high = new_high; // R2 R15
      next_result_low  = conv_result[NIB_W-1:0]; // R1
    end
    if (!ctrl.peak) begin
      next_peak_data  = HIGH_RST; // R12
      next_peak_valid = 1'b0;
    end else if (conv_ok && (!peak_valid || ($signed(new_high) > $signed(peak_data)))) begin
      next_peak_data  = new_high; // R12
      next_peak_valid = 1'b1;
    end
    // Freeze blocks every conversion load; software writes still land
    if (wr && (paddr == ADDR_DISPLAY)) begin
      next_display_data = pwdata[HIGH_W-1:0]; // R13
    end else if (conv_ok && !ctrl.hold && !ctrl.source_serial) begin // R9 R14
      if (ctrl.peak) begin
        next_display_data = next_peak_data; // R8 R13
      end else begin
        next_display_data = new_high; // R13
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl         <= CTRL_RST; // R3
      result_high  <= HIGH_RST;
      result_low   <= NIB_RST;
      peak_data    <= HIGH_RST;
      peak_valid   <= 1'b0;
      display_data <= HIGH_RST;
      irq_mask     <= IRQ_RST;
    end else begin
      ctrl         <= next_ctrl;
      result_high  <= next_result_high;
      result_low   <= next_result_low;
      peak_data    <= next_peak_data;
      peak_valid   <= next_peak_valid;
      display_data <= next_display_data;
      irq_mask     <= next_irq_mask;
    end
  end

  // Sticky events; a set in the clearing cycle survives
  always_comb begin
    next_irq_status = irq_status;
    if (wr && (paddr == ADDR_IRQ_STATUS)) begin
      next_irq_status = irq_status & ~pwdata[IRQ_W-1:0];
    end
    next_irq_status[IRQ_CONV] = next_irq_status[IRQ_CONV] || conv_ok;
    next_irq_status[IRQ_BATT] = next_irq_status[IRQ_BATT] || (battery_below && !battery_low_flag);
    next_irq_status[IRQ_CAL]  = next_irq_status[IRQ_CAL] || (cal_done && ctrl.enhanced_offset_trigger);
  end

  // Display magnitude: negative two's complement codes are inverted, not negated, hence offset by one
  always_comb begin
    next_lcd.negative  = next_display_data[HIGH_W-1]; // R11
    next_lcd.magnitude = next_display_data[HIGH_W-1] ? ~next_display_data : next_display_data; // R11
  end

  // Registered outputs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_status           <= IRQ_RST;
      battery_low_flag     <= 1'b0;
      battery_segment      <= 1'b0;
      offset_cal_each      <= 1'b1;
      enhanced_cal_request <= 1'b0;
      filter_run           <= 1'b1;
      lcd_run              <= 1'b1;
      modulator_run        <= 1'b1;
      buffer_run           <= 1'b1;
      lcd_negative         <= 1'b0;
      lcd_magnitude        <= HIGH_RST;
      irq                  <= 1'b0;
    end else begin
      irq_status           <= next_irq_status;
      battery_low_flag     <= battery_below; // R10
      battery_segment      <= battery_below; // R10
      offset_cal_each      <= !next_ctrl.auto_offset_disable; // R4
      enhanced_cal_request <= next_ctrl.enhanced_offset_trigger; // R5
      filter_run           <= !next_ctrl.digital_powerdown; // R6 R7
      lcd_run              <= !next_ctrl.digital_powerdown; // R6 R7
      modulator_run        <= !next_ctrl.analog_powerdown; // R6 R7
      buffer_run           <= !next_ctrl.analog_powerdown; // R6 R7
      lcd_negative         <= next_lcd.negative;
      lcd_magnitude        <= next_lcd.magnitude;
      irq                  <= |(next_irq_status & next_irq_mask);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_low_nibble;
    pready && !pwrite && !pslverr && (paddr == ADDR_RESULT_LOW) |-> prdata[NIB_W-1:0] == NIB_RST;
  endproperty
  a_low_nibble: assert property (p_low_nibble) else $error("low result nibble not zero"); // R1

  property p_result_word;
    conv_ok |=> {result_high, result_low} == $past(conv_result);
  endproperty
  a_result_word: assert property (p_result_word) else $error("result word not assembled"); // R2

  property p_auto_cal;
    ##1 offset_cal_each == !ctrl.auto_offset_disable;
  endproperty
  a_auto_cal: assert property (p_auto_cal) else $error("per-conversion calibration mismatch"); // R4

  property p_cal_hold;
    enhanced_cal_request && !cal_done |=> enhanced_cal_request;
  endproperty
  a_cal_hold: assert property (p_cal_hold) else $error("calibration request dropped early"); // R5

  property p_powerdown;
    ##1 (filter_run == !ctrl.digital_powerdown) && (lcd_run == filter_run) &&
        (modulator_run == !ctrl.analog_powerdown) && (buffer_run == modulator_run);
  endproperty
  a_powerdown: assert property (p_powerdown) else $error("power-down gating mismatch"); // R6 R7

  property p_peak_rise;
    // First store may be negative, so compare only once a peak already stood
    ctrl.peak && peak_valid && $past(ctrl.peak) && $past(peak_valid) |->
      $signed(peak_data) >= $signed($past(peak_data));
  endproperty
  a_peak_rise: assert property (p_peak_rise) else $error("peak value decreased"); // R8 R12

  property p_peak_clear;
    !ctrl.peak |=> (peak_data == HIGH_RST) && !peak_valid;
  endproperty
  a_peak_clear: assert property (p_peak_clear) else $error("peak not cleared"); // R12

  property p_freeze;
    ctrl.hold && !(wr && (paddr == ADDR_DISPLAY)) |=> $stable(display_data);
  endproperty
  a_freeze: assert property (p_freeze) else $error("frozen display reloaded"); // R9 R14

  property p_battery;
    battery_below |=> battery_low_flag && battery_segment;
  endproperty
  a_battery: assert property (p_battery) else $error("battery flag not raised"); // R10

  property p_neg_display;
    display_data[HIGH_W-1] |-> lcd_negative && (lcd_magnitude == ~display_data);
  endproperty
  a_neg_display: assert property (p_neg_display) else $error("negative display offset wrong"); // R11

  property p_direct_load;
    conv_ok && !ctrl.hold && !ctrl.source_serial && !ctrl.peak && !wr |=> display_data == $past(new_high);
  endproperty
  a_direct_load: assert property (p_direct_load) else $error("display not loaded from result"); // R13

  c_peak_update: cover property (ctrl.peak && conv_ok ##1 $changed(peak_data));
  c_freeze_held: cover property (ctrl.hold && conv_ok);
  c_cal_done:    cover property (enhanced_cal_request ##[1:20] cal_done);
  c_irq:         cover property ($rose(irq));

endmodule

// ==== verif/adcrd_conv_model.sv ====
// Purpose: Far-side model of converter core, calibration engine and battery comparator
// Assumes: Bench asks for a conversion with a one-cycle go strobe
// Notes:   Result lines carry the inverse of the last value outside the strobe
`timescale 1ns/1ps
module adcrd_conv_model
  import adcrd_pkg::*;
#(
  parameter int CAL_CYC = 20
)(
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             go,
  input  wire logic [RES_W-1:0] value,
  input  wire logic             batt_in,
  input  wire logic             cal_request,
  output logic                  conv_done,
  output logic      [RES_W-1:0] conv_result,
  output logic                  cal_done,
  output logic                  battery_below
);
  int cnt;
  // Whole signed word with its strobe; stale lines flip every cycle, so no value holds two cycles running
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      conv_done   <= 1'b0;
      conv_result <= '0;
    end else begin
      conv_done   <= go;
      conv_result <= go ? value : ~conv_result;
    end
  end
  // Calibration finishes some cycles after each request; comparator is registered
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt           <= 0;
      cal_done      <= 1'b0;
      battery_below <= 1'b0;
    end else begin
      battery_below <= batt_in;
      cal_done      <= 1'b0;
      if (cal_request && !cal_done) begin
        cnt <= (cnt == CAL_CYC - 1) ? 0 : cnt + 1;
        if (cnt == CAL_CYC - 1) begin
          cal_done <= 1'b1;
        end
      end
    end
  end
endmodule

// ==== verif/test_adcrd_ctrl.sv ====
// Purpose: Self-checking bench for the result and display control block
// Assumes: APB answer after one wait state; conversion visible two edges after go
// Notes:   Expected values are fixed constants worked out by hand
`timescale 1ns/1ps
module test_adcrd_ctrl
  import adcrd_pkg::*;
;
  logic              clk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rdata;
  logic              conv_done, cal_done, battery_below, go, batt, rerr;
  logic [RES_W-1:0]  conv_result, value;
  logic              offset_cal_each, enhanced_cal_request, filter_run, lcd_run;
  logic              modulator_run, buffer_run, battery_segment, lcd_negative, irq;
  logic [HIGH_W-1:0] lcd_magnitude;
  int                bad_count, n_tests, cycles;
  logic [RES_W-1:0]  pk_in [4] = '{20'h01000, 20'h00500, 20'h02000, 20'hFFF00};
  logic [DATA_W-1:0] pk_ex [4] = '{32'h100, 32'h100, 32'h200, 32'h200};

  adcrd_ctrl dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_done(conv_done), .conv_result(conv_result), .cal_done(cal_done),
    .battery_below(battery_below), .offset_cal_each(offset_cal_each),
    .enhanced_cal_request(enhanced_cal_request), .filter_run(filter_run), .lcd_run(lcd_run),
    .modulator_run(modulator_run), .buffer_run(buffer_run), .battery_segment(battery_segment),
    .lcd_negative(lcd_negative), .lcd_magnitude(lcd_magnitude), .irq(irq));
  adcrd_conv_model #(.CAL_CYC(20)) model (.clk(clk), .reset_n(reset_n), .go(go), .value(value),
    .batt_in(batt), .cal_request(enhanced_cal_request), .conv_done(conv_done),
    .conv_result(conv_result), .cal_done(cal_done), .battery_below(battery_below));

  // 40 MHz clock
  always #12.5 clk = ~clk;

  task automatic conclude();
    $display("tests %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      conclude();
    end
  end

  task automatic chk(input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // One APB transfer; holds everything until pready is sampled high
  task automatic apb(input logic [ADDR_W-1:0] a, input logic w, input logic [DATA_W-1:0] d);
    psel    <= 1'b1;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the bench-wide hang guard ends this wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdata   = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    apb(a, 1'b0, WORD_RST);
    chk(exp, rdata);
  endtask

  // Conversion strobe through the model, then let both edges land
  task automatic conv(input logic [RES_W-1:0] v);
    go    <= 1'b1;
    value <= v;
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic ends(input string s);
    $display("test %s done", s);
  endtask

  initial begin
    {clk, psel, penable, pwrite, go, batt} = '0;
    {paddr, pwdata, value} = '0;
    reset_n = 1'b0;
    bad_count = 0;
    n_tests = 0;
    cycles = 0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    chk(32'h7C, 32'({offset_cal_each, filter_run, lcd_run, modulator_run, buffer_run, irq,
      enhanced_cal_request}));
    rd(ADDR_CTRL, 32'h0);
    rd(ADDR_RESULT_LOW, 32'h0);
    rd(ADDR_PEAK, 32'h0);
    rd(ADDR_DISPLAY, 32'h0);
    rd(8'h20, 32'h0);
    chk(32'h1, 32'(rerr));
    ends("reset");
    conv(20'hABCD5);
    rd(ADDR_RESULT_HIGH, 32'hABCD);
    rd(ADDR_RESULT_LOW, 32'h50);
    rd(ADDR_DISPLAY, 32'hABCD);
    chk(32'h15432, 32'({lcd_negative, lcd_magnitude}));
    conv(20'hFFFFF);
    chk(32'h10000, 32'({lcd_negative, lcd_magnitude}));
    ends("result");
    wr(ADDR_CTRL, 32'h1);
    chk(32'h0, 32'(offset_cal_each));
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CTRL, 32'(i << 2));
      chk(32'({!i[0], !i[0], !i[1], !i[1]}), 32'({filter_run, lcd_run, modulator_run, buffer_run}));
    end
    wr(ADDR_CTRL, 32'h4);
    conv(20'h11110);
    rd(ADDR_RESULT_HIGH, 32'hFFFF);
    ends("powerdown");
    wr(ADDR_CTRL, 32'h20);
    for (int i = 0; i < 4; i++) begin
      conv(pk_in[i]);
      rd(ADDR_PEAK, pk_ex[i]);
      rd(ADDR_DISPLAY, pk_ex[i]);
    end
    wr(ADDR_CTRL, 32'h0);
    rd(ADDR_PEAK, 32'h0);
    ends("peak");
    conv(20'h00700);
    wr(ADDR_CTRL, 32'h40);
    conv(20'h03000);
    rd(ADDR_RESULT_HIGH, 32'h0300);
    rd(ADDR_DISPLAY, 32'h0070);
    wr(ADDR_CTRL, 32'h0);
    rd(ADDR_DISPLAY, 32'h0070);
    conv(20'h00800);
    rd(ADDR_DISPLAY, 32'h0080);
    wr(ADDR_CTRL, 32'h10);
    wr(ADDR_DISPLAY, 32'h1234);
    conv(20'h09000);
    rd(ADDR_DISPLAY, 32'h1234);
    chk(32'h01234, 32'({lcd_negative, lcd_magnitude}));
    wr(ADDR_CTRL, 32'h0);
    ends("display");
    rd(ADDR_IRQ_STATUS, 32'h1);
    wr(ADDR_IRQ_STATUS, 32'h7);
    rd(ADDR_IRQ_STATUS, 32'h0);
    batt <= 1'b1;
    repeat (4) @(posedge clk);
    chk(32'h1, 32'(battery_segment));
    rd(ADDR_STATUS, 32'h1);
    rd(ADDR_IRQ_STATUS, 32'h2);
    chk(32'h0, 32'(irq));
    wr(ADDR_IRQ_MASK, 32'h2);
    chk(32'h1, 32'(irq));
    rd(ADDR_IRQ_MASK, 32'h2);
    wr(ADDR_IRQ_STATUS, 32'h2);
    chk(32'h0, 32'(irq));
    batt <= 1'b0;
    ends("battery");
    wr(ADDR_CTRL, 32'h2);
    chk(32'h1, 32'(enhanced_cal_request));
    rd(ADDR_STATUS, 32'h2);
    repeat (30) @(posedge clk);
    chk(32'h0, 32'(enhanced_cal_request));
    rd(ADDR_IRQ_STATUS, 32'h4);
    ends("calibration");
    conclude();
  end
endmodule
